//--- rtl/pmx_pkg.sv
package pmx_pkg;
    // apb register byte offsets
    localparam logic [3:0]  PMX_OFS_PCFG    = 4'h0;
    localparam logic [3:0]  PMX_OFS_GPIO_EN = 4'h4;
    localparam logic [3:0]  PMX_OFS_GPIO_DR = 4'h8;
    localparam logic [3:0]  PMX_OFS_STATUS  = 4'hC;
    // peripheral_config_reg fields
    localparam int          PMX_PCFG_VP1    = 0;
    localparam int          PMX_PCFG_AUD    = 1;
    localparam int          PMX_PCFG_BSP1   = 2;
    localparam int          PMX_PCFG_W      = 3;
    localparam logic [2:0]  PMX_PCFG_RST    = 3'h4;
    // status register fields
    localparam int          PMX_STAT_PCI    = 0;
    localparam int          PMX_STAT_ETH    = 1;
    // gpio registers
    localparam int          PMX_GPIO_W      = 16;
    localparam logic [15:0] PMX_GPIO_EN_RST = 16'h0000;
    localparam logic [15:0] PMX_GPIO_DR_RST = 16'h0000;
    // gpio bit positions on shared pins
    localparam int          PMX_GP_CLK4     = 1;
    localparam int          PMX_GP_CLK6     = 2;
    localparam int          PMX_GP_DAC      = 8;
    localparam int          PMX_GP_HI_LO    = 9;
    // pin group low bits and widths
    localparam int          PMX_GP_HI_W     = 7;
    localparam int          PMX_VP1_HI_LO   = 12;
    localparam int          PMX_VP1_HI_W    = 8;
    localparam int          PMX_VP1_LO_LO   = 2;
    localparam int          PMX_VP1_LO_W    = 7;
    localparam int          PMX_VP1_W       = 20;
    localparam int          PMX_PCI_W       = 32;
endpackage : pmx_pkg

//--- rtl/pmx_stage.sv
`timescale 1ns/100ps
// one registered stage, used for every pad and fabric return vector
module pmx_stage #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         ce,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] val;
    } pmx_stage_s;

    pmx_stage_s st_q;
    pmx_stage_s st_d;

    always_comb
    begin
        st_d = st_q;
        if (rst)
        begin
            st_d.val = RST;
        end
        else if (ce)
        begin
            st_d.val = d;
        end
    end

    always_ff @(posedge clock)
    begin
        st_q <= st_d;
    end

    assign q = st_q.val;
endmodule : pmx_stage

//--- rtl/pmx_pin_select.sv
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
// Summary of operation
// R1 - software sets shared functions once only; here pcfg, gpio_en and gpio_dir stay writable at any time
// R2 - straps taken only while reset held
// R3 - strapped pins granted to one peripheral
// R4 - gpio enable: direction bit picks in/out
// R5 - clock outputs own gpio1/2 after reset
// R6 - gpio8 needs pci off and enable
// R7 - dac output owns its pin by default
// R8 - gpio15:9 need pci off and enable
// R9 - video1 enable takes upper data pins
// R10 - audio enable takes upper data pins
// R11 - upper data pins unused after reset
// R12 - lower data pins serve serial1 after reset
// R13 - video1 enable takes lower data pins
// R14 - pci off: standalone pci pins hi-z
// R15 - pci strap 1 enables pci, default 0
// R16 - ethernet strap ignored while pci enabled
// R17 - video1 wins over audio when both set
// R18 - unselected pins stay undriven
module pmx_pin_select
    import pmx_pkg::*;
#(
    parameter int PCI_W = pmx_pkg::PMX_PCI_W
) (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      ce,
    // straps
    input  wire logic                      strap_pci_enable,
    input  wire logic                      strap_ethernet_enable,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // peripheral enables
    output logic                           pci_block_enable,
    output logic                           ethernet_block_enable,
    // peripheral side
    input  wire logic                      clock_div4_output,
    input  wire logic                      clock_div6_output,
    input  wire logic                      video_dac_output,
    input  wire logic [PMX_GPIO_W-1:0]     general_purpose_lines_out,
    output logic      [PMX_GPIO_W-1:0]     general_purpose_lines_in,
    input  wire logic [PMX_VP1_W-1:0]      video1_data_bus_out,
    input  wire logic [PMX_VP1_W-1:0]      video1_data_bus_oe,
    output logic      [PMX_VP1_W-1:0]      video1_data_bus_in,
    input  wire logic [7:0]                audio_serial_data_lines_out,
    input  wire logic [7:0]                audio_serial_data_lines_oe,
    output logic      [7:0]                audio_serial_data_lines_in,
    input  wire logic [PMX_VP1_LO_W-1:0]   serial1_out,
    input  wire logic [PMX_VP1_LO_W-1:0]   serial1_oe,
    output logic      [PMX_VP1_LO_W-1:0]   serial1_in,
    input  wire logic [PMX_GP_HI_W-1:0]    pci_shared_out,
    input  wire logic [PMX_GP_HI_W-1:0]    pci_shared_oe,
    output logic      [PMX_GP_HI_W-1:0]    pci_shared_in,
    input  wire logic [PCI_W-1:0]          pci_pin_out,
    input  wire logic [PCI_W-1:0]          pci_pin_oe,
    output logic      [PCI_W-1:0]          pci_pin_in,
    // pads
    output logic      [1:0]                clk_pad_out,
    output logic      [1:0]                clk_pad_oe,
    input  wire logic [1:0]                clk_pad_in,
    output logic                           dac_pad_out,
    output logic                           dac_pad_oe,
    input  wire logic                      dac_pad_in,
    output logic      [PMX_GP_HI_W-1:0]    gphi_pad_out,
    output logic      [PMX_GP_HI_W-1:0]    gphi_pad_oe,
    input  wire logic [PMX_GP_HI_W-1:0]    gphi_pad_in,
    output logic      [PMX_VP1_HI_W-1:0]   vp1hi_pad_out,
    output logic      [PMX_VP1_HI_W-1:0]   vp1hi_pad_oe,
    input  wire logic [PMX_VP1_HI_W-1:0]   vp1hi_pad_in,
    output logic      [PMX_VP1_LO_W-1:0]   vp1lo_pad_out,
    output logic      [PMX_VP1_LO_W-1:0]   vp1lo_pad_oe,
    input  wire logic [PMX_VP1_LO_W-1:0]   vp1lo_pad_in,
    output logic      [PCI_W-1:0]          pci_pad_out,
    output logic      [PCI_W-1:0]          pci_pad_oe,
    input  wire logic [PCI_W-1:0]          pci_pad_in
);
    import pmx_pkg::*;

    localparam int NP = 25 + PCI_W;
    localparam int NF = PMX_GPIO_W + PMX_VP1_W + 8 + PMX_VP1_LO_W + PMX_GP_HI_W + PCI_W;

    typedef struct packed {
        logic                  pci_strap;
        logic                  eth_strap;
        logic [PMX_PCFG_W-1:0] pcfg;
        logic [PMX_GPIO_W-1:0] gpio_en;
        logic [PMX_GPIO_W-1:0] gpio_dir;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  eth_en;
        logic                  live;
    } pmx_sel_s;

    pmx_sel_s st_q;
    pmx_sel_s st_d;

    logic          vp1_on;
    logic          aud_on;
    logic          bsp_on;
    logic          pci_on;
    logic [NP-1:0] pad_o;
    logic [NP-1:0] pad_e;
    logic [NP-1:0] pad_i;
    logic [NP-1:0] pad_oq;
    logic [NP-1:0] pad_eq;
    logic [NF-1:0] fab_d;
    logic [NF-1:0] fab_q;
    logic          acc;
    logic [31:0]   rd;
    logic          hit;

    assign vp1_on = st_q.pcfg[PMX_PCFG_VP1];
    assign aud_on = st_q.pcfg[PMX_PCFG_AUD];
    assign bsp_on = st_q.pcfg[PMX_PCFG_BSP1];
    assign pci_on = st_q.pci_strap;
    assign acc    = psel & penable & ~st_q.pready;
    assign pad_i  = {pci_pad_in, vp1lo_pad_in, vp1hi_pad_in, gphi_pad_in, dac_pad_in, clk_pad_in};

    // read decode; an unmapped word reads zero with an error
    always_comb
    begin
        rd  = 32'h0000_0000;
        hit = 1'b1;
        if (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0)
        begin
            hit = 1'b0;
        end
        else if (paddr[3:0] == PMX_OFS_PCFG)
        begin
            rd[PMX_PCFG_W-1:0] = st_q.pcfg;
        end
        else if (paddr[3:0] == PMX_OFS_GPIO_EN)
        begin
            rd[PMX_GPIO_W-1:0] = st_q.gpio_en;
        end
        else if (paddr[3:0] == PMX_OFS_GPIO_DR)
        begin
            rd[PMX_GPIO_W-1:0] = st_q.gpio_dir;
        end
        else
        begin
            rd[PMX_STAT_PCI] = st_q.pci_strap;
            rd[PMX_STAT_ETH] = st_q.eth_en;
        end
    end

    always_comb
    begin
        st_d = st_q;
        if (rst)
        begin
            // R2 straps sampled in reset
            st_d.pci_strap = strap_pci_enable;
            st_d.eth_strap = strap_ethernet_enable;
            st_d.eth_en    = 1'b0;
            st_d.pcfg      = PMX_PCFG_RST;
            st_d.gpio_en   = PMX_GPIO_EN_RST;
            st_d.gpio_dir  = PMX_GPIO_DR_RST;
            st_d.prdata    = 32'h0000_0000;
            st_d.pready    = 1'b0;
            st_d.pslverr   = 1'b0;
            st_d.live      = 1'b0;
        end
        else if (ce)
        begin
            // R16 ethernet masked by pci
            st_d.eth_en  = st_q.eth_strap & ~st_q.pci_strap;
            st_d.live    = 1'b1;
            st_d.pready  = acc;
            st_d.pslverr = acc & ~hit;
            st_d.prdata  = (acc && !pwrite) ? rd : 32'h0000_0000;
            if (acc && pwrite && hit)
            begin
                if (paddr[3:0] == PMX_OFS_PCFG)
                begin
                    st_d.pcfg = pwdata[PMX_PCFG_W-1:0];
                end
                else if (paddr[3:0] == PMX_OFS_GPIO_EN)
                begin
                    st_d.gpio_en = pwdata[PMX_GPIO_W-1:0];
                end
                else if (paddr[3:0] == PMX_OFS_GPIO_DR)
                begin
                    st_d.gpio_dir = pwdata[PMX_GPIO_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        st_q <= st_d;
    end

    // pad steering, all from registered selections so pads never glitch on a write
    always_comb
    begin
        pad_o = '0;
        pad_e = '0;
        fab_d = '0;
        // R4 R5 clock pins fall back to clocks
        for (int k = 0; k < 2; k++)
        begin
            if (st_q.gpio_en[PMX_GP_CLK4 + k])
            begin
                pad_o[k] = general_purpose_lines_out[PMX_GP_CLK4 + k];
                pad_e[k] = st_q.gpio_dir[PMX_GP_CLK4 + k];
                fab_d[PMX_GP_CLK4 + k] = pad_i[k];
            end
            else
            begin
                pad_o[k] = (k == 0) ? clock_div4_output : clock_div6_output;
                pad_e[k] = 1'b1;
            end
        end
        // R6 R7 gpio8 only with pci off
        if (!pci_on && st_q.gpio_en[PMX_GP_DAC])
        begin
            pad_o[2] = general_purpose_lines_out[PMX_GP_DAC];
            pad_e[2] = st_q.gpio_dir[PMX_GP_DAC];
            fab_d[PMX_GP_DAC] = pad_i[2];
        end
        else
        begin
            pad_o[2] = video_dac_output;
            pad_e[2] = 1'b1;
        end
        for (int k = 0; k < PMX_GP_HI_W; k++)
        begin
            // R3 R15 pci strap owns these
            if (pci_on)
            begin
                pad_o[3 + k] = pci_shared_out[k];
                pad_e[3 + k] = pci_shared_oe[k];
                fab_d[PMX_GPIO_W + PMX_VP1_W + 8 + PMX_VP1_LO_W + k] = pad_i[3 + k];
            end
            // R8 gpio15:9 need enable
            else if (st_q.gpio_en[PMX_GP_HI_LO + k])
            begin
                pad_o[3 + k] = general_purpose_lines_out[PMX_GP_HI_LO + k];
                pad_e[3 + k] = st_q.gpio_dir[PMX_GP_HI_LO + k];
                fab_d[PMX_GP_HI_LO + k] = pad_i[3 + k];
            end
        end
        for (int k = 0; k < PMX_VP1_HI_W; k++)
        begin
            // R9 R17 video1 has priority
            if (vp1_on)
            begin
                pad_o[10 + k] = video1_data_bus_out[PMX_VP1_HI_LO + k];
                pad_e[10 + k] = video1_data_bus_oe[PMX_VP1_HI_LO + k];
                fab_d[PMX_GPIO_W + PMX_VP1_HI_LO + k] = pad_i[10 + k];
            end
            // R10 R11 audio data lines
            else if (aud_on)
            begin
                pad_o[10 + k] = audio_serial_data_lines_out[k];
                pad_e[10 + k] = audio_serial_data_lines_oe[k];
                fab_d[PMX_GPIO_W + PMX_VP1_W + k] = pad_i[10 + k];
            end
        end
        for (int k = 0; k < PMX_VP1_LO_W; k++)
        begin
            // R13 video1 over serial1
            if (vp1_on)
            begin
                pad_o[18 + k] = video1_data_bus_out[PMX_VP1_LO_LO + k];
                pad_e[18 + k] = video1_data_bus_oe[PMX_VP1_LO_LO + k];
                fab_d[PMX_GPIO_W + PMX_VP1_LO_LO + k] = pad_i[18 + k];
            end
            // R12 serial1 default owner
            else if (bsp_on)
            begin
                pad_o[18 + k] = serial1_out[k];
                pad_e[18 + k] = serial1_oe[k];
                fab_d[PMX_GPIO_W + PMX_VP1_W + 8 + k] = pad_i[18 + k];
            end
        end
        // R14 R18 standalone pci tied off
        if (pci_on)
        begin
            pad_o[NP-1:25] = pci_pin_out;
            pad_e[NP-1:25] = pci_pin_oe;
            fab_d[NF-1:NF-PCI_W] = pad_i[NP-1:25];
        end
    end

    pmx_stage #(.W(NP), .RST('0)) u_pad_out (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .d     (pad_o),
        .q     (pad_oq)
    );

    pmx_stage #(.W(NP), .RST('0)) u_pad_oe (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .d     (pad_e),
        .q     (pad_eq)
    );

    pmx_stage #(.W(NF), .RST('0)) u_fabric_in (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .d     (fab_d),
        .q     (fab_q)
    );

    assign {pci_pad_out, vp1lo_pad_out, vp1hi_pad_out, gphi_pad_out, dac_pad_out, clk_pad_out}
        = pad_oq;
    assign {pci_pad_oe, vp1lo_pad_oe, vp1hi_pad_oe, gphi_pad_oe, dac_pad_oe, clk_pad_oe}
        = pad_eq;
    assign {pci_pin_in, pci_shared_in, serial1_in, audio_serial_data_lines_in,
            video1_data_bus_in, general_purpose_lines_in} = fab_q;
    assign prdata                = st_q.prdata;
    assign pready                = st_q.pready;
    assign pslverr               = st_q.pslverr;
    assign pci_block_enable      = st_q.pci_strap;
    assign ethernet_block_enable = st_q.eth_en;

    default clocking cb @(posedge clock);
    endclocking
    // the edge of release still loads reset values, so checks wait one more edge
    default disable iff (rst || !st_q.live);

    chk_strap_held: assert property ($stable(st_q.pci_strap) && $stable(st_q.eth_strap)) // R2
        else $error("strap value changed outside reset");
    chk_clk_default: assert property (ce && !st_q.gpio_en[PMX_GP_CLK4] // R5
        |=> clk_pad_oe[0] && clk_pad_out[0] == $past(clock_div4_output))
        else $error("div4 clock not on its pin");
    chk_gpio_dir: assert property (ce && st_q.gpio_en[PMX_GP_CLK6] // R4
        |=> clk_pad_oe[1] == $past(st_q.gpio_dir[PMX_GP_CLK6]))
        else $error("gpio2 direction not followed");
    chk_gp8_gate: assert property (ce && st_q.pci_strap // R6
        |=> dac_pad_oe && dac_pad_out == $past(video_dac_output))
        else $error("gpio8 took pin with pci on");
    chk_gphi_off: assert property (ce && !st_q.pci_strap && st_q.gpio_en[15:9] == 7'h00 // R8
        |=> gphi_pad_oe == 7'h00)
        else $error("gpio15:9 driven while disabled");
    chk_vp1_prio: assert property (ce && vp1_on // R17
        |=> vp1hi_pad_out == $past(video1_data_bus_out[19:12]))
        else $error("upper data pins not given to video1");
    chk_aud_route: assert property (ce && aud_on && !vp1_on // R10
        |=> vp1hi_pad_oe == $past(audio_serial_data_lines_oe))
        else $error("audio lines not routed");
    chk_bsp_route: assert property (ce && bsp_on && !vp1_on // R12
        |=> vp1lo_pad_out == $past(serial1_out))
        else $error("serial1 not on lower data pins");
    chk_pci_hiz: assert property (!st_q.pci_strap ##1 !st_q.pci_strap // R14
        |-> pci_pad_oe == '0 && pci_pin_in == '0)
        else $error("standalone pci pins active with pci off");
    chk_eth_mask: assert property (ce && st_q.pci_strap |=> !ethernet_block_enable) // R16
        else $error("ethernet enabled while pci on");
    chk_unsel_hiz: assert property (ce && !vp1_on && !aud_on |=> vp1hi_pad_oe == 8'h00) // R18
        else $error("unselected pins driven");
endmodule : pmx_pin_select

//--- dv/pmx_board.sv
`timescale 1ns/100ps
// board side of every shared pad; a pad that the device releases shows the board's
// own driven level, never the device's last value, so a stale return is caught
module pmx_board #(
    parameter int W = 57
) (
    // device pads
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    // board drive
    input  wire logic [W-1:0] board_drv,
    // resolved wire level
    output logic      [W-1:0] pin
);
    assign pin = (pad_out & pad_oe) | (board_drv & ~pad_oe);
endmodule : pmx_board

//--- dv/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    import pmx_pkg::*;
    localparam logic [56:0] BD  = 57'h1A5C3E196D27B48;
    localparam logic [15:0] GEN = 16'hFF06;
    localparam logic [15:0] GDR = 16'h5A02;
    localparam logic [15:0] GPO = 16'hC3A5;
    localparam logic [15:0] GIN = {(GDR[15:9] & GPO[15:9]) | (~GDR[15:9] & BD[9:3]),
                                   BD[2], 5'h00, BD[1], GPO[1], 1'b0};
    localparam logic [19:0] V1O = 20'h3C96A;
    localparam logic [19:0] V1E = 20'h0F0F0;
    localparam logic [7:0]  AO  = 8'h96;
    localparam logic [7:0]  AE  = 8'hF0;
    localparam logic [6:0]  SO  = 7'h2D;
    localparam logic [6:0]  SE  = 7'h4F;
    localparam logic [6:0]  PSO = 7'h33;
    localparam logic [6:0]  PSE = 7'h1E;
    localparam logic [31:0] PPO = 32'h89ABCDEF;
    localparam logic [31:0] PPE = 32'h0FF0F00F;
    int          num_errors = 0;
    int          num_checks = 0;
    logic        clock, rst, ce, strap_pci_enable, strap_ethernet_enable;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, pci_pin_out, pci_pin_oe, pci_pin_in, pci_pad_out, pci_pad_oe;
    logic        pci_block_enable, ethernet_block_enable;
    logic        clock_div4_output, clock_div6_output, video_dac_output, dac_pad_out, dac_pad_oe;
    logic [15:0] general_purpose_lines_out, general_purpose_lines_in;
    logic [19:0] video1_data_bus_out, video1_data_bus_oe, video1_data_bus_in;
    logic [7:0]  audio_serial_data_lines_out, audio_serial_data_lines_oe;
    logic [7:0]  audio_serial_data_lines_in, vp1hi_pad_out, vp1hi_pad_oe;
    logic [6:0]  serial1_out, serial1_oe, serial1_in, pci_shared_out, pci_shared_oe;
    logic [6:0]  pci_shared_in, gphi_pad_out, gphi_pad_oe, vp1lo_pad_out, vp1lo_pad_oe;
    logic [1:0]  clk_pad_out, clk_pad_oe;
    wire  [56:0] pin;

    pmx_pin_select #(.PCI_W(32)) uut (
        .clock(clock), .rst(rst), .ce(ce), .strap_pci_enable(strap_pci_enable),
        .strap_ethernet_enable(strap_ethernet_enable), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pci_block_enable(pci_block_enable),
        .ethernet_block_enable(ethernet_block_enable), .clock_div4_output(clock_div4_output),
        .clock_div6_output(clock_div6_output), .video_dac_output(video_dac_output),
        .general_purpose_lines_out(general_purpose_lines_out),
        .general_purpose_lines_in(general_purpose_lines_in),
        .video1_data_bus_out(video1_data_bus_out), .video1_data_bus_oe(video1_data_bus_oe),
        .video1_data_bus_in(video1_data_bus_in),
        .audio_serial_data_lines_out(audio_serial_data_lines_out),
        .audio_serial_data_lines_oe(audio_serial_data_lines_oe),
        .audio_serial_data_lines_in(audio_serial_data_lines_in), .serial1_out(serial1_out),
        .serial1_oe(serial1_oe), .serial1_in(serial1_in), .pci_shared_out(pci_shared_out),
        .pci_shared_oe(pci_shared_oe), .pci_shared_in(pci_shared_in),
        .pci_pin_out(pci_pin_out), .pci_pin_oe(pci_pin_oe), .pci_pin_in(pci_pin_in),
        .clk_pad_out(clk_pad_out), .clk_pad_oe(clk_pad_oe), .clk_pad_in(pin[1:0]),
        .dac_pad_out(dac_pad_out), .dac_pad_oe(dac_pad_oe), .dac_pad_in(pin[2]),
        .gphi_pad_out(gphi_pad_out), .gphi_pad_oe(gphi_pad_oe), .gphi_pad_in(pin[9:3]),
        .vp1hi_pad_out(vp1hi_pad_out), .vp1hi_pad_oe(vp1hi_pad_oe), .vp1hi_pad_in(pin[17:10]),
        .vp1lo_pad_out(vp1lo_pad_out), .vp1lo_pad_oe(vp1lo_pad_oe), .vp1lo_pad_in(pin[24:18]),
        .pci_pad_out(pci_pad_out), .pci_pad_oe(pci_pad_oe), .pci_pad_in(pin[56:25])
    );

    pmx_board #(.W(57)) board (
        .pad_out({pci_pad_out, vp1lo_pad_out, vp1hi_pad_out, gphi_pad_out, dac_pad_out,
                  clk_pad_out}),
        .pad_oe({pci_pad_oe, vp1lo_pad_oe, vp1hi_pad_oe, gphi_pad_oe, dac_pad_oe, clk_pad_oe}),
        .board_drv(BD),
        .pin(pin)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task report_and_stop();
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // request held until pready is seen at a rising edge; the wait is bounded
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] ex, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(r, ex)
        `CHK(e, ee)
    endtask : rdc

    task automatic wrt(input logic [11:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        `CHK(e, ee)
    endtask : wrt

    // pads follow a config change one edge later, returns two; three leaves margin
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask : settle

    task automatic reset_dut(input logic p, input logic e);
        @(posedge clock);
        rst                   <= 1'b1;
        strap_pci_enable      <= p;
        strap_ethernet_enable <= e;
        repeat (3) @(posedge clock);
        rst                   <= 1'b0;
        settle();
    endtask : reset_dut

    initial
    begin
        rst <= 1'b1;
        ce  <= 1'b1;
        {strap_pci_enable, strap_ethernet_enable, psel, penable, pwrite} <= 5'h00;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        {clock_div4_output, clock_div6_output, video_dac_output} <= 3'b101;
        general_purpose_lines_out <= GPO;
        {video1_data_bus_out, video1_data_bus_oe} <= {V1O, V1E};
        {audio_serial_data_lines_out, audio_serial_data_lines_oe} <= {AO, AE};
        {serial1_out, serial1_oe, pci_shared_out, pci_shared_oe} <= {SO, SE, PSO, PSE};
        {pci_pin_out, pci_pin_oe} <= {PPO, PPE};
        for (int s = 0; s < 4; s++)
        begin
            reset_dut(s[0], s[1]);
            `CHK(pci_block_enable, s[0])
            `CHK(ethernet_block_enable, s[1] & ~s[0])
            // straps move after reset; the latched selection must not
            @(posedge clock);
            strap_pci_enable      <= ~s[0];
            strap_ethernet_enable <= ~s[1];
            rdc({8'h00, PMX_OFS_STATUS}, {30'h0, s[1] & ~s[0], s[0]}, 1'b0);
        end
        reset_dut(1'b0, 1'b1);
        `CHK(clk_pad_oe, 2'b11)
        `CHK(clk_pad_out, 2'b01)
        `CHK({dac_pad_oe, dac_pad_out}, 2'b11)
        `CHK({gphi_pad_oe, vp1hi_pad_oe, pci_pad_oe}, 47'h0)
        `CHK({vp1lo_pad_oe, vp1lo_pad_out & SE}, {SE, SO & SE})
        `CHK(serial1_in, (SO & SE) | (BD[24:18] & ~SE))
        `CHK({pci_pin_in, pci_shared_in, audio_serial_data_lines_in}, 47'h0)
        `CHK(general_purpose_lines_in, 16'h0000)
        rdc({8'h00, PMX_OFS_PCFG}, {29'h0, PMX_PCFG_RST}, 1'b0);
        rdc({8'h00, PMX_OFS_GPIO_EN}, 32'h0, 1'b0);
        rdc({8'h00, PMX_OFS_GPIO_DR}, 32'h0, 1'b0);
        rdc(12'h010, 32'h0, 1'b1);
        wrt(12'h001, 32'h0, 1'b1);
        rdc({8'h00, PMX_OFS_PCFG}, 32'h4, 1'b0);
        wrt({8'h00, PMX_OFS_STATUS}, 32'h3, 1'b0);
        rdc({8'h00, PMX_OFS_STATUS}, 32'h2, 1'b0);
        // each selection is set once after a reset and left alone
        wrt({8'h00, PMX_OFS_GPIO_EN}, {16'h0, GEN}, 1'b0);
        wrt({8'h00, PMX_OFS_GPIO_DR}, {16'h0, GDR}, 1'b0);
        rdc({8'h00, PMX_OFS_GPIO_DR}, {16'h0, GDR}, 1'b0);
        settle();
        `CHK({clk_pad_oe, clk_pad_out[0]}, {2'b01, GPO[1]})
        `CHK(dac_pad_oe, 1'b0)
        `CHK(gphi_pad_oe, GDR[15:9])
        `CHK(gphi_pad_out & GDR[15:9], GPO[15:9] & GDR[15:9])
        `CHK(general_purpose_lines_in, GIN)
        reset_dut(1'b0, 1'b0);
        wrt({8'h00, PMX_OFS_PCFG}, 32'h2, 1'b0);
        settle();
        `CHK({vp1hi_pad_oe, vp1hi_pad_out & AE}, {AE, AO & AE})
        `CHK(audio_serial_data_lines_in, (AO & AE) | (BD[17:10] & ~AE))
        `CHK({vp1lo_pad_oe, serial1_in, video1_data_bus_in}, 34'h0)
        reset_dut(1'b0, 1'b0);
        wrt({8'h00, PMX_OFS_PCFG}, 32'h7, 1'b0);
        settle();
        `CHK(vp1hi_pad_oe, V1E[19:12])
        `CHK(vp1hi_pad_out & V1E[19:12], V1O[19:12] & V1E[19:12])
        `CHK({vp1lo_pad_oe, vp1lo_pad_out & V1E[8:2]}, {V1E[8:2], V1O[8:2] & V1E[8:2]})
        `CHK({audio_serial_data_lines_in, serial1_in}, 15'h0)
        `CHK(video1_data_bus_in[19:12], V1O[19:12] & V1E[19:12] | (BD[17:10] & ~V1E[19:12]))
        // ce low must freeze the pads even though the video data moves
        @(posedge clock);
        ce                  <= 1'b0;
        video1_data_bus_out <= ~V1O;
        settle();
        `CHK(vp1hi_pad_out & V1E[19:12], V1O[19:12] & V1E[19:12])
        @(posedge clock);
        ce                  <= 1'b1;
        reset_dut(1'b1, 1'b1);
        wrt({8'h00, PMX_OFS_GPIO_EN}, 32'hFF00, 1'b0);
        settle();
        `CHK({gphi_pad_oe, gphi_pad_out & PSE}, {PSE, PSO & PSE})
        `CHK(pci_shared_in, (PSO & PSE) | (BD[9:3] & ~PSE))
        `CHK({pci_pad_oe, pci_pad_out & PPE}, {PPE, PPO & PPE})
        `CHK(pci_pin_in, (PPO & PPE) | (BD[56:25] & ~PPE))
        `CHK(general_purpose_lines_in, 16'h0000)
        `CHK({dac_pad_oe, dac_pad_out}, 2'b11)
        report_and_stop();
    end
endmodule : tb_top
